// *** verilog/flash_pec_pkg.sv ***
`default_nettype none
package flash_pec_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  KEY_OFS     = 8'h04;
   localparam logic [7:0]  OPTKEY_OFS  = 8'h08;
   localparam logic [7:0]  STATUS_OFS  = 8'h0c;
   localparam logic [7:0]  CONTROL_OFS = 8'h10;
   localparam logic [7:0]  ADDR_OFS    = 8'h14;
   localparam logic [7:0]  DATA_OFS    = 8'h18;

   localparam logic [31:0] UNLOCK_KEY1 = 32'h45670123;
   localparam logic [31:0] UNLOCK_KEY2 = 32'hcdef89ab;

   // ------------------------------------------------------------
   // Control word fields
   // ------------------------------------------------------------
   localparam int unsigned CTL_STD_PROG   = 0;
   localparam int unsigned CTL_SECTOR     = 1;
   localparam int unsigned CTL_MASS       = 2;
   localparam int unsigned CTL_OPT_PROG   = 4;
   localparam int unsigned CTL_OPT_ERASE  = 5;
   localparam int unsigned CTL_START      = 6;
   localparam int unsigned CTL_LOCK       = 7;
   localparam int unsigned CTL_OPT_WE     = 9;
   localparam int unsigned CTL_FAULT_IE   = 10;
   localparam int unsigned CTL_DONE_IE    = 12;
   localparam int unsigned CTL_FAST_LOCK  = 15;
   localparam int unsigned CTL_FAST_PROG  = 16;
   localparam int unsigned CTL_FAST_ERASE = 17;
   localparam int unsigned CTL_BUF_PUSH   = 18;
   localparam int unsigned CTL_BUF_CLEAR  = 19;
   localparam logic [31:0] CTL_RW_MASK    = 32'h0003_1437;

   // ------------------------------------------------------------
   // Status word fields
   // ------------------------------------------------------------
   localparam int unsigned ST_BUSY       = 0;
   localparam int unsigned ST_PROG_FAULT = 2;
   localparam int unsigned ST_PROT_FAULT = 4;
   localparam int unsigned ST_DONE       = 5;

   localparam int unsigned PAGE_BYTES = 64;
   localparam int unsigned WORD_BYTES = 4;
   localparam int unsigned PAGE_WORDS = PAGE_BYTES / WORD_BYTES;

   typedef enum logic [2:0] {
      OP_NONE, OP_STD_PROG, OP_SECTOR_ERASE, OP_MASS_ERASE,
      OP_OPT_ERASE, OP_OPT_PROG, OP_FAST_PROG, OP_FAST_ERASE
   } flash_op_t;
endpackage
`default_nettype wire

// *** verilog/flash_op_if.sv ***
`default_nettype none
interface flash_op_if;
   import flash_pec_pkg::*;
   logic      start;
   flash_op_t op;
   logic      busy;
   logic      done;
   logic      prog_fault;
   logic      prot_fault;
   modport ctrl (output start, op, input busy, done, prog_fault, prot_fault);
   modport seq  (input start, op, output busy, done, prog_fault, prot_fault);
endinterface
`default_nettype wire

// *** verilog/flash_key_check.sv ***
`default_nettype none
module flash_key_check (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        key_we_i,
   input  wire logic [31:0] key_i,
   output logic             unlock_o,
   output logic             fail_o
);
   import flash_pec_pkg::*;

   typedef enum logic {KEY_WAIT_FIRST, KEY_WAIT_SECOND} key_state_t;
   key_state_t state_reg;

   wire first_ok  = key_i == UNLOCK_KEY1;
   wire second_ok = key_i == UNLOCK_KEY2;

   always_ff @(posedge ref_clk_i) begin
      unlock_o <= 1'b0;
      fail_o   <= 1'b0;
      if (reset_i) begin
         state_reg <= KEY_WAIT_FIRST;
      end else if (key_we_i) begin
         case (state_reg)
            KEY_WAIT_FIRST: begin
               state_reg <= first_ok ? KEY_WAIT_SECOND : KEY_WAIT_FIRST;
               fail_o    <= !first_ok;
            end
            default: begin
               state_reg <= KEY_WAIT_FIRST;
               unlock_o  <= second_ok;
               fail_o    <= !second_ok;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** verilog/flash_op_seq.sv ***
`default_nettype none
module flash_op_seq (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_i,
   flash_op_if.seq               op_if,
   input  wire logic             flash_ack_i,
   input  wire logic             flash_prog_err_i,
   input  wire logic             flash_prot_err_i,
   output logic                  flash_req_o,
   output flash_pec_pkg::flash_op_t flash_op_o
);
   import flash_pec_pkg::*;

   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
   seq_state_t state_reg;

   assign op_if.busy = state_reg == SEQ_RUN;

   // Request stays up until the array acknowledges; one op at a time
   always_ff @(posedge ref_clk_i) begin
      op_if.done       <= 1'b0;
      op_if.prog_fault <= 1'b0;
      op_if.prot_fault <= 1'b0;
      if (reset_i) begin
         state_reg   <= SEQ_IDLE;
         flash_req_o <= 1'b0;
         flash_op_o  <= OP_NONE;
      end else begin
         case (state_reg)
            SEQ_IDLE: if (op_if.start) begin
               state_reg   <= SEQ_RUN;
               flash_req_o <= 1'b1;
               flash_op_o  <= op_if.op;
            end
            default: if (flash_ack_i) begin
               state_reg        <= SEQ_IDLE;
               flash_req_o      <= 1'b0;
               flash_op_o       <= OP_NONE;
               op_if.done       <= !(flash_prog_err_i || flash_prot_err_i);
               op_if.prog_fault <= flash_prog_err_i;
               op_if.prot_fault <= flash_prot_err_i;
            end
         endcase
      end
   end

   chk_busy_until_ack:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      op_if.busy && !flash_ack_i |=> op_if.busy)
      else $error("busy dropped before the array acknowledged");
endmodule
`default_nettype wire

// *** verilog/flash_program_erase_control.sv ***
// Overview of operation
// - While the main lock is set, control, address and data writes are ignored; resets set.
// - The main lock bit accepts only writes of one, for re-locking.
// - Only the correct key pair clears the lock; a failed try freezes it.
// - The fast lock bit accepts only writes of one.
// - Writing start launches the chosen erase or fast program; it clears when busy falls.
// - Done interrupt enable routes the end-of-operation flag to the interrupt.
// - Fault interrupt enable routes program or protection faults to the interrupt.
// - Writing zero clears option write enable; writing one does nothing.
// - Fast erase select picks a one page, 64 byte erase.
// - Fast program select picks page programming over word programming.
// - Option erase select picks erasure of the user option area.
// - Option program select picks programming of user option bytes.
// - Mass erase select picks erasure of the whole user area.
// - Sector erase select picks erasure of one 1K sector.
// - Standard program select makes data writes program the array.
// - Busy stays high for the whole operation and falls at its end.
// - Done flag sets on each successful operation; write one clears it.
`default_nettype none
module flash_program_erase_control #(
   parameter int unsigned ADDR_W = flash_pec_pkg::ADDR_W
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_i,
   input  wire logic [ADDR_W-1:0]        addr_i,
   input  wire logic [31:0]              wr_data_i,
   input  wire logic                     wr_en_i,
   input  wire logic                     rd_en_i,
   output logic      [31:0]              rd_data_o,
   output logic                          irq_o,
   output logic                          flash_req_o,
   output flash_pec_pkg::flash_op_t      flash_op_o,
   output logic      [31:0]              flash_addr_o,
   output logic      [31:0]              flash_wdata_o,
   input  wire logic                     flash_ack_i,
   input  wire logic                     flash_prog_err_i,
   input  wire logic                     flash_prot_err_i,
   input  wire logic [$clog2(flash_pec_pkg::PAGE_WORDS)-1:0] buf_rd_idx_i,
   output logic      [31:0]              buf_rd_data_o
);
   import flash_pec_pkg::*;

   localparam int unsigned        IDX_W    = $clog2(PAGE_WORDS);
   localparam int unsigned        PTR_W    = IDX_W + 1;
   localparam logic [PTR_W-1:0]   PTR_FULL = PTR_W'(PAGE_WORDS);
   localparam logic [ADDR_W-1:0]  A_KEY    = ADDR_W'(KEY_OFS);
   localparam logic [ADDR_W-1:0]  A_OPTKEY = ADDR_W'(OPTKEY_OFS);
   localparam logic [ADDR_W-1:0]  A_STATUS = ADDR_W'(STATUS_OFS);
   localparam logic [ADDR_W-1:0]  A_CTL    = ADDR_W'(CONTROL_OFS);
   localparam logic [ADDR_W-1:0]  A_ADDR   = ADDR_W'(ADDR_OFS);
   localparam logic [ADDR_W-1:0]  A_DATA   = ADDR_W'(DATA_OFS);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic             lock_reg;
   logic             frozen_reg;
   logic             fast_lock_reg;
   logic             opt_we_reg;
   logic             start_reg;
   logic [31:0]      ctl_rw_reg;
   logic             done_reg;
   logic             prog_fault_reg;
   logic             prot_fault_reg;
   logic [31:0]      addr_reg;
   logic [31:0]      data_reg;
   logic [31:0]      page_buf [PAGE_WORDS];
   logic [PTR_W-1:0] buf_ptr_reg;
   logic             main_unlock;
   logic             main_fail;
   logic             opt_unlock;
   logic [31:0]      status_word;
   logic [31:0]      control_word;
   logic [31:0]      rd_data_next;

   flash_op_if op_if ();

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire wr_key    = wr_en_i && addr_i == A_KEY;
   wire wr_optkey = wr_en_i && addr_i == A_OPTKEY;
   wire wr_status = wr_en_i && addr_i == A_STATUS;
   wire wr_ctl    = wr_en_i && addr_i == A_CTL && !lock_reg;
   wire busy      = op_if.busy;
   wire wr_addr   = wr_en_i && addr_i == A_ADDR && !lock_reg && !busy;
   wire wr_data   = wr_en_i && addr_i == A_DATA && !lock_reg && !busy;

   // A failed try only freezes a locked controller; keys sent while
   // unlocked are simply ignored
   wire unlock_ok = main_unlock && lock_reg && !frozen_reg;
   // Start falls on the acknowledging edge, so it drops in step with busy
   wire op_end    = busy && flash_ack_i;

   // ------------------------------------------------------------
   // Operation selection
   // ------------------------------------------------------------
   wire [31:0] sel = wr_data_i;
   wire erase_pick_opt   = sel[CTL_OPT_ERASE];
   wire erase_pick_mass  = sel[CTL_MASS];
   wire erase_pick_sect  = sel[CTL_SECTOR];
   wire erase_pick_fast  = sel[CTL_FAST_ERASE];
   wire erase_pick_fprog = sel[CTL_FAST_PROG];

   wire flash_op_t start_op = erase_pick_opt   ? OP_OPT_ERASE    :
                              erase_pick_mass  ? OP_MASS_ERASE   :
                              erase_pick_sect  ? OP_SECTOR_ERASE :
                              erase_pick_fast  ? OP_FAST_ERASE   :
                              erase_pick_fprog ? OP_FAST_PROG    : OP_NONE;

   wire fast_op    = start_op == OP_FAST_ERASE || start_op == OP_FAST_PROG;
   wire opt_op     = start_op == OP_OPT_ERASE;
   wire start_cmd  = wr_ctl && sel[CTL_START] && !start_reg && !busy;
   wire refused    = start_op == OP_NONE || (fast_op && fast_lock_reg) ||
                     (opt_op && !opt_we_reg);
   wire launch_st  = start_cmd && !refused;

   // Word programming is triggered by a data write; option bytes need the
   // option write enable to be open
   wire flash_op_t prog_op = (ctl_rw_reg[CTL_OPT_PROG] && opt_we_reg) ?
                             OP_OPT_PROG :
                             ctl_rw_reg[CTL_STD_PROG] ? OP_STD_PROG : OP_NONE;
   wire launch_pg  = wr_data && prog_op != OP_NONE;

   assign op_if.start = launch_st || launch_pg;
   assign op_if.op    = launch_st ? start_op : prog_op;

   // ------------------------------------------------------------
   // Lock bits
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         lock_reg      <= 1'b1;
         frozen_reg    <= 1'b0;
         fast_lock_reg <= 1'b1;
      end else begin
         if (unlock_ok) lock_reg <= 1'b0;
         else if (wr_ctl && sel[CTL_LOCK]) lock_reg <= 1'b1;
         if (main_fail && lock_reg) frozen_reg <= 1'b1;
         if (unlock_ok) fast_lock_reg <= 1'b0;
         else if (wr_ctl && sel[CTL_FAST_LOCK]) fast_lock_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Control bits
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         opt_we_reg <= 1'b0;
         start_reg  <= 1'b0;
         ctl_rw_reg <= '0;
      end else begin
         if (opt_unlock && !lock_reg) opt_we_reg <= 1'b1;
         else if (wr_ctl && !sel[CTL_OPT_WE]) opt_we_reg <= 1'b0;
         if (launch_st) start_reg <= 1'b1;
         else if (op_end) start_reg <= 1'b0;
         if (wr_ctl) ctl_rw_reg <= sel & CTL_RW_MASK;
      end
   end

   // ------------------------------------------------------------
   // Status flags, set wins over a same-cycle clear
   // ------------------------------------------------------------
   wire clr_done = wr_status && wr_data_i[ST_DONE];
   wire clr_pf   = wr_status && wr_data_i[ST_PROG_FAULT];
   wire clr_wp   = wr_status && wr_data_i[ST_PROT_FAULT];
   wire set_pf   = op_if.prog_fault || (start_cmd && refused);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         done_reg       <= 1'b0;
         prog_fault_reg <= 1'b0;
         prot_fault_reg <= 1'b0;
      end else begin
         done_reg       <= op_if.done || (done_reg && !clr_done);
         prog_fault_reg <= set_pf || (prog_fault_reg && !clr_pf);
         prot_fault_reg <= op_if.prot_fault || (prot_fault_reg && !clr_wp);
      end
   end

   // ------------------------------------------------------------
   // Address, data and page buffer
   // ------------------------------------------------------------
   wire buf_clear = wr_ctl && sel[CTL_BUF_CLEAR];
   wire buf_push  = wr_ctl && sel[CTL_BUF_PUSH] && buf_ptr_reg != PTR_FULL;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         addr_reg    <= '0;
         data_reg    <= '0;
         buf_ptr_reg <= '0;
      end else begin
         if (wr_addr) addr_reg <= wr_data_i;
         if (wr_data) data_reg <= wr_data_i;
         if (buf_clear) buf_ptr_reg <= '0;
         else if (buf_push) buf_ptr_reg <= buf_ptr_reg + 1'b1;
      end
   end

   // Buffer words carry no reset; an emptied buffer is marked by the pointer
   always_ff @(posedge ref_clk_i) begin
      if (buf_push) page_buf[buf_ptr_reg[IDX_W-1:0]] <= data_reg;
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      status_word                = '0;
      status_word[ST_BUSY]       = busy;
      status_word[ST_PROG_FAULT] = prog_fault_reg;
      status_word[ST_PROT_FAULT] = prot_fault_reg;
      status_word[ST_DONE]       = done_reg;
      control_word                = ctl_rw_reg;
      control_word[CTL_START]     = start_reg;
      control_word[CTL_LOCK]      = lock_reg;
      control_word[CTL_OPT_WE]    = opt_we_reg;
      control_word[CTL_FAST_LOCK] = fast_lock_reg;
   end

   always_comb begin
      if (addr_i == A_STATUS) rd_data_next = status_word;
      else if (addr_i == A_CTL) rd_data_next = control_word;
      else if (addr_i == A_ADDR) rd_data_next = addr_reg;
      else if (addr_i == A_DATA) rd_data_next = data_reg;
      else rd_data_next = '0;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   wire irq_next = (ctl_rw_reg[CTL_DONE_IE] && done_reg) ||
                   (ctl_rw_reg[CTL_FAULT_IE] &&
                    (prog_fault_reg || prot_fault_reg));

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rd_data_o     <= '0;
         irq_o         <= 1'b0;
         buf_rd_data_o <= '0;
      end else begin
         rd_data_o     <= rd_en_i ? rd_data_next : '0;
         irq_o         <= irq_next;
         buf_rd_data_o <= page_buf[buf_rd_idx_i];
      end
   end

   assign flash_addr_o  = addr_reg;
   assign flash_wdata_o = data_reg;

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   flash_key_check main_key (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .key_we_i  (wr_key),
      .key_i     (wr_data_i),
      .unlock_o  (main_unlock),
      .fail_o    (main_fail)
   );

   flash_key_check option_key (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .key_we_i  (wr_optkey),
      .key_i     (wr_data_i),
      .unlock_o  (opt_unlock),
      .fail_o    ()
   );

   flash_op_seq sequencer (
      .ref_clk_i        (ref_clk_i),
      .reset_i          (reset_i),
      .op_if            (op_if.seq),
      .flash_ack_i      (flash_ack_i),
      .flash_prog_err_i (flash_prog_err_i),
      .flash_prot_err_i (flash_prot_err_i),
      .flash_req_o      (flash_req_o),
      .flash_op_o       (flash_op_o)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_locked_ctl_frozen:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      lock_reg && wr_en_i && addr_i == A_CTL |=> $stable(ctl_rw_reg))
      else $error("control changed while locked");

   chk_lock_write_one:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      lock_reg && !unlock_ok |=> lock_reg)
      else $error("lock cleared without key pair");

   chk_frozen_keeps_lock:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      frozen_reg |-> lock_reg)
      else $error("lock opened after failed attempt");

   chk_fast_refused:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      start_cmd && fast_op && fast_lock_reg |-> !op_if.start ##1 prog_fault_reg)
      else $error("fast op launched while fast lock set");

   chk_fast_lock_sticky:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      fast_lock_reg && !unlock_ok |=> fast_lock_reg)
      else $error("fast lock cleared by a write");

   chk_start_follows_op:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      launch_st |=> start_reg && busy)
      else $error("start did not launch an operation");

   chk_start_clear_end:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      start_reg ##1 !busy |-> !start_reg)
      else $error("start not cleared when busy fell");

   chk_done_irq:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      done_reg && ctl_rw_reg[CTL_DONE_IE] |=> irq_o)
      else $error("done interrupt missing");

   chk_irq_masked:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !ctl_rw_reg[CTL_FAULT_IE] && !(done_reg && ctl_rw_reg[CTL_DONE_IE]) |=> !irq_o)
      else $error("interrupt raised while disabled");

   chk_opt_we_key:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !opt_we_reg ##1 opt_we_reg |-> $past(opt_unlock))
      else $error("option write enable set without key");

   chk_done_flag_set:
   assert property (@(posedge ref_clk_i) disable iff (reset_i)
      op_if.done |=> done_reg)
      else $error("done flag not set");
endmodule
`default_nettype wire

// *** sim/flash_array_model.sv ***
`default_nettype none
module flash_array_model (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   input  wire logic       req_i,
   input  wire logic [3:0] delay_i,
   input  wire logic [1:0] err_mode_i,
   output logic            ack_o,
   output logic            prog_err_o,
   output logic            prot_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] count_reg;
   logic       toggle_reg = 1'b0;
   // Error lines only mean something beside ack, so they wander otherwise
   assign prog_err_o = ack_o ? (err_mode_i == 2'd1) : toggle_reg;
   assign prot_err_o = ack_o ? (err_mode_i == 2'd2) : ~toggle_reg;
   always @(posedge ref_clk_i) begin
      toggle_reg <= ~toggle_reg;
      if (reset_i || !req_i || ack_o) begin
         count_reg <= 4'h0;
         ack_o     <= 1'b0;
      end else begin
         count_reg <= count_reg + 4'h1;
         ack_o     <= (count_reg + 4'h1 == delay_i);
      end
   end
endmodule
`default_nettype wire

// *** sim/flash_program_erase_control_tb.sv ***
`default_nettype none
module flash_program_erase_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_pec_pkg::*;
   logic        ref_clk_i, reset_i = 1, wr_en_i = 0, rd_en_i = 0, irq_o, flash_req_o;
   logic        flash_ack_i, flash_prog_err_i, flash_prot_err_i;
   logic [7:0]  addr_i = 0;
   logic [3:0]  buf_rd_idx_i = 0, delay = 6;
   logic [1:0]  err_mode = 0;
   logic [31:0] wr_data_i = 0, rd_data_o, flash_addr_o, flash_wdata_o, buf_rd_data_o, v, d;
   flash_op_t   flash_op_o;
   int          fail_count = 0, checked = 0, cycles = 0;
   integer      seed = 32'hb9fc95b9;
   int          sel [4] = '{CTL_SECTOR, CTL_MASS, CTL_FAST_ERASE, CTL_FAST_PROG};
   flash_program_erase_control uut (.ref_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_en_i,
      .rd_en_i, .rd_data_o, .irq_o, .flash_req_o, .flash_op_o, .flash_addr_o, .flash_wdata_o,
      .flash_ack_i, .flash_prog_err_i, .flash_prot_err_i, .buf_rd_idx_i, .buf_rd_data_o);
   flash_array_model array (.ref_clk_i, .reset_i, .req_i(flash_req_o), .delay_i(delay),
      .err_mode_i(err_mode), .ack_o(flash_ack_i), .prog_err_o(flash_prog_err_i),
      .prot_err_o(flash_prot_err_i));
   initial begin
      ref_clk_i = 0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic do_reset();
      reset_i <= 1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= x;
      wr_en_i <= 1;
      @(posedge ref_clk_i);
      wr_en_i <= 0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_en_i <= 1;
      @(posedge ref_clk_i);
      rd_en_i <= 0;
      #1 x = rd_data_o;
   endtask
   function automatic flash_op_t op_of(input logic [31:0] c);
      if (c[CTL_MASS]) return OP_MASS_ERASE;
      if (c[CTL_SECTOR]) return OP_SECTOR_ERASE;
      if (c[CTL_FAST_ERASE]) return OP_FAST_ERASE;
      return OP_FAST_PROG;
   endfunction
   function automatic logic [31:0] st_of(input logic [1:0] e);
      return (e == 1) ? 32'h4 : (e == 2) ? 32'h10 : 32'h20;
   endfunction
   task automatic run_op(input logic [7:0] a, input logic [31:0] x, c, input flash_op_t o);
      logic [31:0] r;
      logic [1:0]  e;
      int          n;
      r = $random(seed);
      e = (r[1:0] == 3) ? 2'd0 : r[1:0];
      err_mode <= e;
      delay <= 4'd6 + {1'b0, r[4:2]};
      wr(a, x);
      chk("request", {31'h0, flash_req_o}, 1);
      chk("op", {29'h0, flash_op_o}, {29'h0, o});
      rd(CONTROL_OFS, r);
      chk("start", {31'h0, r[CTL_START]}, {31'h0, a == CONTROL_OFS});
      rd(STATUS_OFS, r);
      chk("busy", r, 1);
      n = 0;
      while (flash_req_o !== 0 && n < 40) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      rd(STATUS_OFS, r);
      chk("end status", r, st_of(e));
      chk("irq", {31'h0, irq_o}, {31'h0, (e == 0) ? c[12] : c[10]});
      if (a == DATA_OFS) chk("wdata", flash_wdata_o, x);
      rd(CONTROL_OFS, r);
      chk("start end", {31'h0, r[CTL_START]}, 0);
      wr(STATUS_OFS, st_of(e));
      rd(STATUS_OFS, r);
      chk("status clear", r, 0);
      chk("irq clear", {31'h0, irq_o}, 0);
   endtask
   task automatic refuse(input logic [31:0] x);
      logic [31:0] r;
      wr(CONTROL_OFS, x);
      chk("refused", {31'h0, flash_req_o}, 0);
      rd(STATUS_OFS, r);
      chk("fault", r, 32'h4);
      wr(STATUS_OFS, r);
   endtask
   initial begin
      do_reset();
      rd(CONTROL_OFS, v);
      chk("ctl reset", v, 32'h8080);
      wr(CONTROL_OFS, 32'h2);
      wr(ADDR_OFS, 32'h1234);
      rd(8'h3c, v);
      chk("unmapped", v, 0);
      rd(CONTROL_OFS, v);
      chk("locked", v, 32'h8080);
      chk("addr locked", flash_addr_o, 0);
      wr(KEY_OFS, UNLOCK_KEY1);
      wr(KEY_OFS, UNLOCK_KEY2);
      rd(CONTROL_OFS, v);
      chk("unlocked", v, 0);
      $display("test lock done");
      for (int i = 0; i < 8; i++) begin
         d = (32'h1 << sel[i % 4]) | ($random(seed) & 32'h1400) | 32'h40;
         run_op(CONTROL_OFS, d, d, op_of(d));
      end
      wr(ADDR_OFS, d);
      chk("addr", flash_addr_o, d);
      rd(ADDR_OFS, v);
      chk("addr read", v, d);
      d = ($random(seed) & 32'h1400) | 32'h1;
      wr(CONTROL_OFS, d);
      rd(CONTROL_OFS, v);
      chk("start idle", {31'h0, v[CTL_START]}, 0);
      run_op(DATA_OFS, $random(seed), d, OP_STD_PROG);
      wr(OPTKEY_OFS, UNLOCK_KEY1);
      wr(OPTKEY_OFS, UNLOCK_KEY2);
      rd(CONTROL_OFS, v);
      chk("opt enable", v & 32'h200, 32'h200);
      run_op(CONTROL_OFS, 32'h260, 32'h260, OP_OPT_ERASE);
      wr(CONTROL_OFS, 32'h210);
      run_op(DATA_OFS, $random(seed), 32'h210, OP_OPT_PROG);
      wr(CONTROL_OFS, 0);
      rd(CONTROL_OFS, v);
      chk("opt relock", v, 0);
      refuse(32'h60);
      $display("test ops done");
      wr(CONTROL_OFS, 32'h8000);
      wr(CONTROL_OFS, 0);
      rd(CONTROL_OFS, v);
      chk("fast lock", v, 32'h8000);
      refuse(32'h20040);
      refuse(32'h10040);
      refuse(32'h40);
      d = $random(seed);
      wr(CONTROL_OFS, 32'h88000);
      wr(DATA_OFS, d);
      wr(CONTROL_OFS, 32'h48000);
      repeat (2) @(posedge ref_clk_i);
      #1 chk("buffer", buf_rd_data_o, d);
      wr(CONTROL_OFS, 32'h80);
      wr(CONTROL_OFS, 0);
      wr(KEY_OFS, UNLOCK_KEY1);
      wr(KEY_OFS, 0);
      wr(KEY_OFS, UNLOCK_KEY1);
      wr(KEY_OFS, UNLOCK_KEY2);
      rd(CONTROL_OFS, v);
      chk("frozen", v, 32'h8080);
      do_reset();
      wr(KEY_OFS, UNLOCK_KEY1);
      wr(KEY_OFS, UNLOCK_KEY2);
      rd(CONTROL_OFS, v);
      chk("thawed", v, 0);
      $display("test relock done");
      report_and_stop();
   end
endmodule
`default_nettype wire
